// ==== edge_capture_interval_timer.sv ====
// edge capture registers and programmable interval timer
// assumes an Avalon-MM master on clk; edge pins and sample clock are asynchronous
`timescale 1ns/1ps
`default_nettype none

module edge_capture_interval_timer
  import edge_capture_interval_timer_pkg::*;
#(
  parameter int COUNT_W = 16,     // free-running counter width
  parameter int INTERVAL_W = 12   // interval timer width
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // external pins
  input wire logic edge_input_zero,
  input wire logic edge_input_one,
  input wire logic counter_sample_clock,
  // interrupt requests to the controller
  output logic capture0Irq,
  output logic capture1Irq,
  output logic intervalIrq
);

  // synchronised edge pulses
  logic in0Rise, in0Fall, in1Rise, in1Fall;
  logic tick;                         // one pulse per sample clock rise
  logic [2:0] pinVec;                 // pins into the synchroniser loop
  logic [2:0] riseVec, fallVec;       // edge pulses out of it

  // bus state
  logic busAck_r, busAck_nxt;         // second cycle of a transfer
  logic [31:0] readdata_r, readdata_nxt;
  logic [5:0] regIdx;                 // word index of the access
  logic wordOk;                       // aligned access
  logic rdFirst;                      // first cycle of a read, side effects here
  logic wrAcc;                        // write takes effect

  // control registers
  logic [7:0] cfg_r, cfg_nxt;         // hold, byte select, wide join
  logic [3:0] irqEn_r, irqEn_nxt;     // capture interrupt enables
  logic holdOn;                       // first-edge hold mode
  logic wideJoin;                     // capture zero extended to 16 bits
  logic [SEL_W-1:0] byteSel;          // counter window select

  // counter and interval timer
  logic [COUNT_W-1:0] cnt_r, cnt_nxt;
  logic [INTERVAL_W-1:0] ivl_r, ivl_nxt;
  logic [7:0] reloadLow_r, reloadLow_nxt;
  logic [NIB_W-1:0] reloadHigh_r, reloadHigh_nxt;
  logic [NIB_W-1:0] holdNib_r, holdNib_nxt;
  logic ivlIrq_r, ivlIrq_nxt;

  // capture results gathered from the per-entry blocks
  logic [7:0] capVal [NUM_CAP];
  logic [NUM_CAP-1:0] capFlag;
  logic [NUM_CAP-1:0] evt;            // status-setting events
  logic [7:0] window;                 // selected eight counter bits
  logic [1:0] capIrq_r, capIrq_nxt;

  // three asynchronous pins, each through two flops
  assign pinVec = {counter_sample_clock, edge_input_one, edge_input_zero};

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_pin
      edge_sync u_sync (
        .clk(clk),
        .reset(reset),
        .pinIn(pinVec[p]),
        .level(),
        .rise(riseVec[p]),
        .fall(fallVec[p])
      );
    end
  endgenerate

  assign in0Rise = riseVec[0];
  assign in0Fall = fallVec[0];
  assign in1Rise = riseVec[1];
  assign in1Fall = fallVec[1];
  assign tick = riseVec[2];

  // configuration fields
  assign holdOn = cfg_r[CFG_HOLD_BIT];
  assign wideJoin = cfg_r[CFG_WIDE_BIT];
  assign byteSel = cfg_r[CFG_SEL_LSB +: SEL_W];

  // window slides up one bit per select step
  assign window = 8'(cnt_r >> byteSel);

  // capture one is silenced while joined to capture zero
  assign evt = {in1Fall & ~wideJoin, in1Rise & ~wideJoin, in0Fall, in0Rise};

  // bus decode
  assign regIdx = address[7:2];
  assign wordOk = (address[1:0] == 2'h0);
  assign rdFirst = read & ~busAck_r & wordOk;
  assign wrAcc = write & busAck_r & wordOk & byteenable[0];

  // one wait cycle on every access
  assign waitrequest = (read | write) & ~busAck_r;
  assign readdata = readdata_r;

  // per-entry capture register, hold lock and status flag
  genvar i;
  generate
    for (i = 0; i < NUM_CAP; i++) begin : g_cap
      logic [7:0] val_r, val_nxt;     // captured time
      logic lock_r, lock_nxt;         // first edge held, awaiting read
      logic flag_r, flag_nxt;         // status bit
      logic load;                     // this register loads now
      logic lockSrc;                  // lock that governs the load
      logic readHit;                  // software reads this register
      logic [7:0] sample;             // bits to store

      // entry 2/3 follow entry 0/1 when joined
      if (i < 2) begin : g_low
        assign load = evt[i];
        assign lockSrc = lock_r;
        // zero registers hold the low byte when joined
        assign sample = wideJoin ? cnt_r[7:0] : window;
      end else begin : g_high
        assign load = wideJoin ? evt[i-2] : evt[i];
        assign lockSrc = wideJoin ? g_cap[i-2].lock_r : lock_r;
        // high byte when joined, else own input window
        assign sample = wideJoin ? cnt_r[15:8] : window;
      end

      assign readHit = rdFirst & (regIdx == CAP_INDEX[i]);

      // next values of this entry
      always_comb begin
        val_nxt = val_r;
        lock_nxt = lock_r;
        // a held first edge blocks later loads until read
        if (load && !(holdOn && lockSrc)) begin
          val_nxt = sample;
        end
        // reading releases the hold
        if (readHit) begin
          lock_nxt = 1'b0;
        end
        // a load in hold mode locks, winning over a read release
        if (load && holdOn) begin
          lock_nxt = 1'b1;
        end
        // write one clears, write zero
        flag_nxt = flag_r;
        if (wrAcc && regIdx == CAP_IRQ_FLAG_IDX && writedata[i]) begin
          flag_nxt = 1'b0;
        end
        // an edge sets its flag, set wins over clear
        if (evt[i]) begin
          flag_nxt = 1'b1;
        end
      end

      // register this entry
      always_ff @(posedge clk) begin
        if (reset) begin
          val_r <= BYTE_RST;
          lock_r <= 1'b0;
          flag_r <= 1'b0;
        end else begin
          val_r <= val_nxt;
          lock_r <= lock_nxt;
          flag_r <= flag_nxt;
        end
      end

      assign capVal[i] = val_r;
      assign capFlag[i] = flag_r;
    end
  endgenerate

  // counter, interval timer and interrupt next values
  always_comb begin
    cnt_nxt = cnt_r;
    ivl_nxt = ivl_r;
    ivlIrq_nxt = 1'b0;
    holdNib_nxt = holdNib_r;
    // counter advances only on sample clock ticks
    if (tick) begin
      cnt_nxt = cnt_r + 1'b1;
      // count down, reload and pulse at terminal count
      if (ivl_r == '0) begin
        ivl_nxt = {reloadHigh_r, reloadLow_r};
        ivlIrq_nxt = 1'b1;
      end else begin
        ivl_nxt = ivl_r - 1'b1;
      end
    end
    // low byte read freezes the upper nibble for a coherent pair
    if (rdFirst && regIdx == IVL_COUNT_LOW_IDX) begin
      holdNib_nxt = ivl_r[INTERVAL_W-1:8];
    end
    // each capture pair raises its request when flag and enable agree
    capIrq_nxt[0] = |(capFlag[1:0] & irqEn_r[1:0]);
    capIrq_nxt[1] = |(capFlag[3:2] & irqEn_r[3:2]);
  end

  // register counter, interval timer and requests
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= '0;
      ivl_r <= '0;
      ivlIrq_r <= 1'b0;
      holdNib_r <= NIB_RST;
      capIrq_r <= 2'h0;
    end else begin
      cnt_r <= cnt_nxt;
      ivl_r <= ivl_nxt;
      ivlIrq_r <= ivlIrq_nxt;
      holdNib_r <= holdNib_nxt;
      capIrq_r <= capIrq_nxt;
    end
  end

  assign capture0Irq = capIrq_r[0];
  assign capture1Irq = capIrq_r[1];
  assign intervalIrq = ivlIrq_r;

  // writable registers next values
  always_comb begin
    cfg_nxt = cfg_r;
    irqEn_nxt = irqEn_r;
    reloadLow_nxt = reloadLow_r;
    reloadHigh_nxt = reloadHigh_r;
    if (wrAcc) begin
      case (regIdx)
        TIMER_CFG_IDX: begin
          cfg_nxt = writedata[7:0] & CFG_WRITE_MASK;
        end
        // enables for the four capture interrupts
        CAP_IRQ_EN_IDX: begin
          irqEn_nxt = writedata[3:0];
        end
        // low byte first, then the nibble
        IVL_RELOAD_LOW_IDX: begin
          reloadLow_nxt = writedata[7:0];
        end
        IVL_RELOAD_HIGH_IDX: begin
          reloadHigh_nxt = writedata[3:0];
        end
        default: begin
          // read-only or unmapped: ignored
        end
      endcase
    end
  end

  // register writable state
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_r <= BYTE_RST;
      irqEn_r <= NIB_RST;
      reloadLow_r <= BYTE_RST;
      reloadHigh_r <= NIB_RST;
    end else begin
      cfg_r <= cfg_nxt;
      irqEn_r <= irqEn_nxt;
      reloadLow_r <= reloadLow_nxt;
      reloadHigh_r <= reloadHigh_nxt;
    end
  end

  // bus handshake and read data next values
  always_comb begin
    busAck_nxt = (read | write) & ~busAck_r;
    readdata_nxt = readdata_r;
    if (read && !busAck_r) begin
      readdata_nxt = 32'h0000_0000;
      if (wordOk) begin
        case (regIdx)
          CAP0_RISE_IDX: readdata_nxt[7:0] = capVal[0];
          CAP0_FALL_IDX: readdata_nxt[7:0] = capVal[1];
          CAP1_RISE_IDX: readdata_nxt[7:0] = capVal[2];
          CAP1_FALL_IDX: readdata_nxt[7:0] = capVal[3];
          IVL_COUNT_LOW_IDX: readdata_nxt[7:0] = ivl_r[7:0];
          // held nibble, reserved bits zero
          IVL_COUNT_HIGH_IDX: readdata_nxt[3:0] = holdNib_r;
          IVL_RELOAD_LOW_IDX: readdata_nxt[7:0] = reloadLow_r;
          IVL_RELOAD_HIGH_IDX: readdata_nxt[3:0] = reloadHigh_r;
          TIMER_CFG_IDX: readdata_nxt[7:0] = cfg_r;
          CAP_IRQ_EN_IDX: readdata_nxt[3:0] = irqEn_r;
          // status bits, upper bits reserved
          CAP_IRQ_FLAG_IDX: readdata_nxt[3:0] = capFlag;
          default: readdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // register bus state
  always_ff @(posedge clk) begin
    if (reset) begin
      busAck_r <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end else begin
      busAck_r <= busAck_nxt;
      readdata_r <= readdata_nxt;
    end
  end

endmodule // edge_capture_interval_timer

`default_nettype wire

// ==== edge_capture_interval_timer_pkg.sv ====
// package for the edge capture and interval timer block
// assumes one 250 MHz clock and a word-per-register Avalon-MM slave port

package edge_capture_interval_timer_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] CAP0_RISE_IDX = 6'h22;
  localparam logic [5:0] CAP1_RISE_IDX = 6'h23;
  localparam logic [5:0] CAP0_FALL_IDX = 6'h24;
  localparam logic [5:0] CAP1_FALL_IDX = 6'h25;
  localparam logic [5:0] IVL_COUNT_LOW_IDX = 6'h26;
  localparam logic [5:0] IVL_COUNT_HIGH_IDX = 6'h27;
  localparam logic [5:0] IVL_RELOAD_LOW_IDX = 6'h28;
  localparam logic [5:0] IVL_RELOAD_HIGH_IDX = 6'h29;
  localparam logic [5:0] TIMER_CFG_IDX = 6'h2A;
  localparam logic [5:0] CAP_IRQ_EN_IDX = 6'h2B;
  localparam logic [5:0] CAP_IRQ_FLAG_IDX = 6'h2C;

  // capture entry order: 0 in0 rise, 1 in0 fall, 2 in1 rise, 3 in1 fall
  localparam logic [5:0] CAP_INDEX [4] = '{CAP0_RISE_IDX, CAP0_FALL_IDX,
                                           CAP1_RISE_IDX, CAP1_FALL_IDX};

  // timer configuration field positions
  localparam int CFG_HOLD_BIT = 7;
  localparam int CFG_SEL_LSB = 4;
  localparam int CFG_WIDE_BIT = 3;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hF8;

  // number of capture entries and widths of fields
  localparam int NUM_CAP = 4;
  localparam int SEL_W = 3;
  localparam int NIB_W = 4;

  // values after reset
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] NIB_RST = 4'h0;

endpackage : edge_capture_interval_timer_pkg

// ==== edge_capture_interval_timer_properties.sv ====
// port checker for the edge capture and interval timer block
// assumes one clock, synchronous reset, strobes low during reset
`timescale 1ns/1ps
`default_nettype none
module edge_capture_interval_timer_properties (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // pins and requests
  input wire logic edge_input_zero,
  input wire logic edge_input_one,
  input wire logic capture0Irq,
  input wire logic capture1Irq,
  input wire logic intervalIrq
);
  // accesses that complete at this edge
  logic rdAck, wrAck;
  assign rdAck = read & ~waitrequest;
  assign wrAck = write & ~waitrequest;
  // cycles since a pin moved, and the last completed read
  logic [3:0] quiet_r, quiet_nxt;
  logic [1:0] pins_r;
  logic [7:0] lastAddr_r;
  logic [31:0] lastData_r;
  // saturating quiet count
  always_comb begin
    quiet_nxt = quiet_r;
    if (pins_r != {edge_input_one, edge_input_zero}) quiet_nxt = 4'h0;
    else if (quiet_r != 4'hF) quiet_nxt = quiet_r + 4'h1;
  end
  // helper registers
  always_ff @(posedge clk) begin
    pins_r <= {edge_input_one, edge_input_zero};
    quiet_r <= reset ? 4'h0 : quiet_nxt;
    lastAddr_r <= reset ? 8'h00 : (rdAck ? address : lastAddr_r);
    lastData_r <= rdAck ? readdata : lastData_r;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_IRQ_AFTER_RESET: assert property ($past(reset) |->
    !capture0Irq && !capture1Irq && !intervalIrq) else $error("request high after reset");
  AST_BUS_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered");
  AST_EN_RSVD: assert property (rdAck && address == 8'hAC |-> readdata[31:4] == 28'h0)
    else $error("enable upper bits set");
  AST_FLAG_RSVD: assert property (rdAck && address == 8'hB0 |-> readdata[31:4] == 28'h0)
    else $error("status upper bits set");
  AST_CNT_HIGH_RSVD: assert property (rdAck && address == 8'h9C |-> readdata[31:4] == 28'h0)
    else $error("count high upper bits set");
  AST_HIGH_HELD: assert property (rdAck && address == 8'h9C && lastAddr_r == 8'h9C
    |-> readdata == lastData_r) else $error("held nibble moved");
  AST_W1C_CLEARS: assert property (wrAck && address == 8'hB0 && byteenable[0] &&
    writedata[3:0] == 4'hF && quiet_r >= 4'd10 |=> ##1 !capture0Irq && !capture1Irq)
    else $error("clear left request high");
  AST_IRQ_NEEDS_CAUSE: assert property ($rose(capture0Irq) && quiet_r >= 4'd10 |->
    $past(wrAck, 2) || $past(wrAck, 1)) else $error("request rose without cause");
  AST_IVL_PULSE: assert property (intervalIrq |=> !intervalIrq)
    else $error("interval request longer than one cycle");
endmodule // edge_capture_interval_timer_properties
bind edge_capture_interval_timer edge_capture_interval_timer_properties u_props (
  .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .edge_input_zero(edge_input_zero),
  .edge_input_one(edge_input_one), .capture0Irq(capture0Irq),
  .capture1Irq(capture1Irq), .intervalIrq(intervalIrq));
`default_nettype wire

// ==== edge_source.sv ====
// far-side model: two edge pins and the counter sample clock
// assumes the bench calls its tasks; the sample clock stands still between bursts
`timescale 1ns/1ps
`default_nettype none
module edge_source (
  // bench clock
  input wire logic clk,
  // pins towards the block
  output logic pinZero,
  output logic pinOne,
  output logic sampleClk
);
  int ticks = 0; // sample ticks issued since start
  initial begin
    pinZero = 1'b0;
    pinOne = 1'b0;
    sampleClk = 1'b0;
  end
  // n sample ticks, two cycles high and two low each
  task automatic tick(input int n);
    repeat (n) begin
      repeat (2) @(posedge clk);
      sampleClk <= 1'b1;
      repeat (2) @(posedge clk);
      sampleClk <= 1'b0;
      ticks++;
    end
  endtask
  // move one pin, then give the sync chain time to settle
  task automatic setPin(input bit one, input logic v);
    @(posedge clk);
    if (one) pinOne <= v;
    else pinZero <= v;
    repeat (12) @(posedge clk);
  endtask
endmodule // edge_source
`default_nettype wire

// ==== edge_sync.sv ====
// two-flop synchroniser with edge detection for one pin
// assumes the pin is asynchronous to clk; pulses last one clock
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pin from outside
  input wire logic pinIn,
  // synchronised level and edge pulses
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_r, meta_nxt;   // first stage, read only by the second
  logic sync_r, sync_nxt;   // second stage, safe level
  logic prev_r, prev_nxt;   // delayed copy for edge detection

  // next values of the chain
  always_comb begin
    meta_nxt = pinIn;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  // register the chain
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // edges seen only after both stages
  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule // edge_sync

`default_nettype wire

// ==== test_edge_capture_interval_timer.sv ====
// self-checking bench for the edge capture and interval timer block
// assumes the edge_source model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module test_edge_capture_interval_timer;
  logic clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [3:0] byteenable = 4'hF;
  logic waitrequest, pinZero, pinOne, sampleClk, capture0Irq, capture1Irq, intervalIrq;
  int num_errors = 0, cmp_count = 0, t, c;
  always #2 clk = ~clk;
  edge_source u_edge_source (.clk(clk), .pinZero(pinZero), .pinOne(pinOne),
    .sampleClk(sampleClk));
  edge_capture_interval_timer u_edge_capture_interval_timer (.clk(clk), .reset(reset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .edge_input_zero(pinZero), .edge_input_one(pinOne), .counter_sample_clock(sampleClk),
    .capture0Irq(capture0Irq), .capture1Irq(capture1Irq), .intervalIrq(intervalIrq));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 40) begin
      num_errors++;
      $display("[ERR] %0t bus hang %h %h", $time, a, 8'h00);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  // counter window for a byte select
  function automatic logic [31:0] win(input int s);
    return {24'h0, 8'(u_edge_source.ticks >> s)};
  endfunction
  // reset values, unmapped place, read-only place
  task automatic test_reset();
    for (int a = 8'h88; a <= 8'hB0; a += 4) rd(8'(a), 32'h0);
    rd(8'hFC, 32'h0);
    wr(8'h88, 8'hFF);
    rd(8'h88, 32'h0);
    // a write with the low byte lane off is ignored
    byteenable <= 4'hE;
    wr(8'hAC, 8'h0F);
    byteenable <= 4'hF;
    rd(8'hAC, 32'h0);
    wr(8'hAC, 8'hFF);
    rd(8'hAC, 32'h0F);
    wr(8'hAC, 8'h00);
  endtask
  // every byte select, both inputs, status set and cleared
  task automatic test_select();
    u_edge_source.tick(437);
    for (int s = 0; s < 8; s++) begin
      wr(8'hA8, 8'(s << 4));
      u_edge_source.setPin(1'b0, 1'b1);
      rd(8'h88, win(s));
      u_edge_source.setPin(1'b0, 1'b0);
    end
    rd(8'h90, win(7));
    u_edge_source.setPin(1'b1, 1'b1);
    rd(8'h8C, win(7));
    u_edge_source.setPin(1'b1, 1'b0);
    rd(8'h94, win(7));
    rd(8'hB0, 32'h0F);
    wr(8'hB0, 8'h05);
    rd(8'hB0, 32'h0A);
    wr(8'hB0, 8'h00);
    rd(8'hB0, 32'h0A);
    wr(8'hB0, 8'h0A);
    rd(8'hB0, 32'h00);
  endtask
  // requests follow status and enable
  task automatic test_irq();
    wr(8'hAC, 8'h01);
    u_edge_source.setPin(1'b0, 1'b1);
    chk(capture0Irq, 1);
    u_edge_source.setPin(1'b0, 1'b0);
    wr(8'hB0, 8'h01);
    repeat (2) @(posedge clk);
    chk(capture0Irq, 0);
    wr(8'hAC, 8'h02);
    repeat (2) @(posedge clk);
    chk(capture0Irq, 1);
    wr(8'hB0, 8'h0F);
    repeat (2) @(posedge clk);
    chk(capture0Irq, 0);
    wr(8'hAC, 8'h0C);
    u_edge_source.setPin(1'b1, 1'b1);
    chk(capture1Irq, 1);
    wr(8'hB0, 8'h04);
    repeat (2) @(posedge clk);
    chk(capture1Irq, 0);
    u_edge_source.setPin(1'b1, 1'b0);
    chk(capture1Irq, 1);
    wr(8'hB0, 8'h0F);
    wr(8'hAC, 8'h00);
  endtask
  // joined sixteen-bit capture; input one ignored
  task automatic test_wide();
    wr(8'hA8, 8'h08);
    u_edge_source.tick(300);
    c = u_edge_source.ticks;
    u_edge_source.setPin(1'b0, 1'b1);
    rd(8'h88, win(0));
    rd(8'h8C, win(8));
    // move the high byte on, so that a stray input-one load would show
    u_edge_source.tick(300);
    u_edge_source.setPin(1'b1, 1'b1);
    u_edge_source.setPin(1'b1, 1'b0);
    rd(8'h8C, {24'h0, 8'(c >> 8)});
    rd(8'hB0, 32'h01);
    u_edge_source.setPin(1'b0, 1'b0);
    rd(8'h90, win(0));
    rd(8'h94, win(8));
  endtask
  // first edge kept until read
  task automatic test_hold();
    wr(8'hA8, 8'h80);
    xfer(1'b0, 8'h88, 8'h00);
    c = u_edge_source.ticks;
    u_edge_source.setPin(1'b0, 1'b1);
    u_edge_source.setPin(1'b0, 1'b0);
    u_edge_source.tick(5);
    u_edge_source.setPin(1'b0, 1'b1);
    rd(8'h88, {24'h0, 8'(c)});
    u_edge_source.setPin(1'b0, 1'b0);
    u_edge_source.tick(5);
    u_edge_source.setPin(1'b0, 1'b1);
    rd(8'h88, win(0));
    u_edge_source.setPin(1'b0, 1'b0);
    wr(8'hA8, 8'h00);
    wr(8'hB0, 8'h0F);
  endtask
  // reload, period of the interval request, coherent readback
  task automatic test_interval();
    wr(8'hA0, 8'h03);
    wr(8'hA4, 8'h00);
    rd(8'hA0, 32'h03);
    fork
      u_edge_source.tick(40);
      begin
        repeat (2) begin
          t = 0;
          while (intervalIrq !== 1'b1 && t < 200) begin
            @(posedge clk);
            t++;
          end
          repeat (2) @(posedge clk);
        end
        t = 0;
        do begin
          @(posedge clk);
          t++;
        end while (intervalIrq !== 1'b1 && t < 200);
      end
    join
    // period is four ticks of four cycles; t starts two edges after a pulse
    chk(t + 2, 16);
    xfer(1'b0, 8'h98, 8'h00);
    c = q[7:0];
    xfer(1'b0, 8'h9C, 8'h00);
    chk(q[31:4], 0);
    chk(({q[3:0], 8'(c)} <= 12'h003), 1);
    rd(8'h9C, 32'h0);
    // forty ticks of a period of four leave the count at zero
    wr(8'hA4, 8'h01);
    u_edge_source.tick(4);
    rd(8'h98, 32'h00);
    u_edge_source.tick(1);
    rd(8'h9C, 32'h01);
    rd(8'h98, 32'hFF);
    rd(8'h9C, 32'h00);
  endtask
  // verdict and end of run
  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    test_reset();
    test_select();
    test_irq();
    test_wide();
    test_hold();
    test_interval();
    stop_test();
  end
endmodule // test_edge_capture_interval_timer
`default_nettype wire
